// [core/crc_readout_pkg.sv]
// constants and carrier types for the signature readout block
// assumes the crc engine elsewhere supplies reference and live values
//
// What this block does
// R1: hold the 32-bit signature readable by user logic
// R2: load and shift only on readout clock rise
// R3: shift toward serial out while shifting selected
// R4: user holds load select low two cycles
// R5: source select 0 loads pre-computed crc
// R6: source select 1 loads calculated signature
// R7: source select ignored while shifting
// R8: error flag timed by oscillator clock
// R9: flag high when live crc differs from reference
// R10: flag routed to bidirectional pin, enable high
// R11: user supplies 31 more clocks per readout
// R12: system pulses config_restart_n low on error
// R13: trust the flag, not the serial signature
// R14: correct operation resumes after reconfiguration
// R15: bit 0 appears right after a load
package crc_readout_pkg;
  localparam int unsigned SIG_WIDTH = 32;
  localparam int unsigned LOAD_HOLD_CYCLES = 2;
  localparam int unsigned SHIFT_TAIL_CYCLES = 31;
  localparam int unsigned OSC_FREQ_MHZ = 80;
  localparam logic [31:0] SIG_RESET = 32'h0000_0000;
  localparam logic [2:0] SYNC_RESET = 3'h0;

  typedef struct packed {
    logic shift_not_load;
    logic load_source_select;
  } readout_ctrl_t;

  typedef struct packed {
    logic [SIG_WIDTH-1:0] precomputed;
    logic [SIG_WIDTH-1:0] calculated;
  } crc_values_t;
endpackage : crc_readout_pkg

// [core/crc_error_flag.sv]
// error flag stage on the oscillator clock
// assumes crc values are stable in the oscillator domain
`timescale 1ns/1ps
module crc_error_flag (
  // oscillator domain
  input wire logic i_osc_clk,
  input wire logic i_osc_resetn,
  // comparison
  input wire logic i_check_valid,
  input wire crc_readout_pkg::crc_values_t i_values,
  // flag
  output logic o_error
);
  import crc_readout_pkg::*;

  logic error;
  logic next_error;

  // clears only through reset, i.e. reconfiguration (see R14)
  always_comb begin
    next_error = error;
    if (i_check_valid && (i_values.precomputed != i_values.calculated)) begin
      next_error = 1'b1; // see R9
    end
  end

  always_ff @(posedge i_osc_clk) begin
    if (!i_osc_resetn) begin
      error <= 1'b0;
    end else begin
      error <= next_error; // see R8
    end
  end

  assign o_error = error;

  a_flag_sets: assert property (@(posedge i_osc_clk) // see R9
    disable iff (!i_osc_resetn)
    i_check_valid && (i_values.precomputed != i_values.calculated)
    |=> o_error)
    else $error("error flag not raised on mismatch");

  a_flag_sticky: assert property (@(posedge i_osc_clk) // see R14
    disable iff (!i_osc_resetn)
    o_error |=> o_error)
    else $error("error flag dropped without reset");
endmodule : crc_error_flag

// [core/crc_signature_readout.sv]
// signature shift register on the user readout clock plus error flag
// assumes user logic drives readout clock and selects synchronously
`timescale 1ns/1ps
module crc_signature_readout (
  // oscillator domain
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_check_valid,
  input wire crc_readout_pkg::crc_values_t i_values,
  // readout domain
  input wire logic i_readout_clk,
  input wire logic i_readout_resetn,
  input wire crc_readout_pkg::readout_ctrl_t i_ctrl,
  output logic o_serial_signature_out,
  // error flag pin
  output logic o_error_flag_out,
  output logic o_error_flag_oe,
  input wire logic i_error_flag_in,
  output logic o_core_error
);
  import crc_readout_pkg::*;

  // three-stage filter: a level counts once stages two and three agree
  function automatic logic settle_level(input logic [2:0] stages,
    input logic seen);
    logic level;
    level = seen;
    if (stages[1] == stages[2]) begin
      level = stages[2];
    end
    return level;
  endfunction : settle_level

  logic [SIG_WIDTH-1:0] shift_reg;
  logic [SIG_WIDTH-1:0] next_shift_reg;
  // oscillator side of the value crossing
  crc_values_t hold;
  crc_values_t next_hold;
  logic req;
  logic next_req;
  logic [2:0] ack_sync;
  logic [2:0] next_ack_sync;
  logic ack_seen;
  logic next_ack_seen;
  logic busy;
  // readout side of the value crossing
  logic [2:0] req_sync;
  logic [2:0] next_req_sync;
  logic req_seen;
  logic next_req_seen;
  logic ack;
  logic next_ack;
  crc_values_t snap;
  crc_values_t next_snap;
  logic err_raw;
  logic [2:0] err_sync;
  logic [2:0] next_err_sync;
  logic core_error;
  logic next_core_error;

  // error flag in oscillator domain (see R8)
  crc_error_flag u_flag (
    .i_osc_clk(i_clk),
    .i_osc_resetn(i_resetn),
    .i_check_valid(i_check_valid),
    .i_values(i_values),
    .o_error(err_raw)
  );

  // output enable held high so core can see the flag (see R10)
  assign o_error_flag_out = err_raw;
  assign o_error_flag_oe = 1'b1;

  // word crosses by toggle handshake; hold stays frozen until the readout
  // side has taken it, so no half-updated word is ever sampled
  assign busy = (req != ack_seen);

  always_comb begin
    next_ack_sync = {ack_sync[1:0], ack};
    next_ack_seen = settle_level(ack_sync, ack_seen);
    next_hold = hold;
    next_req = req;
    if (i_check_valid && !busy) begin
      next_hold = i_values;
      next_req = !req;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      hold <= '0;
      req <= 1'b0;
      ack_sync <= SYNC_RESET;
      ack_seen <= 1'b0;
    end else begin
      hold <= next_hold;
      req <= next_req;
      ack_sync <= next_ack_sync;
      ack_seen <= next_ack_seen;
    end
  end

  // new word only after a fresh round trip; latency is several readout
  // cycles, acceptable since the crc values change rarely
  always_comb begin
    next_req_sync = {req_sync[1:0], req};
    next_req_seen = settle_level(req_sync, req_seen);
    next_ack = ack;
    next_snap = snap;
    if (req_seen != ack) begin
      next_snap = hold;
      next_ack = req_seen;
    end
  end

  always_ff @(posedge i_readout_clk) begin
    if (!i_readout_resetn) begin
      req_sync <= SYNC_RESET;
      req_seen <= 1'b0;
      ack <= 1'b0;
      snap <= '0;
    end else begin
      req_sync <= next_req_sync;
      req_seen <= next_req_seen;
      ack <= next_ack;
      snap <= next_snap;
    end
  end

  // shift toward serial out, lsb first (see R15)
  always_comb begin
    next_shift_reg = shift_reg;
    if (i_ctrl.shift_not_load) begin
      next_shift_reg = {1'b0, shift_reg[SIG_WIDTH-1:1]}; // see R3, R7
    end else if (i_ctrl.load_source_select) begin
      next_shift_reg = snap.calculated; // see R6
    end else begin
      next_shift_reg = snap.precomputed; // see R5
    end
  end

  always_ff @(posedge i_readout_clk) begin // see R2
    if (!i_readout_resetn) begin
      shift_reg <= SIG_RESET;
    end else begin
      shift_reg <= next_shift_reg; // see R1
    end
  end

  assign o_serial_signature_out = shift_reg[0];

  // pin return to core: three stages, change taken when last two agree
  always_comb begin
    next_err_sync = {err_sync[1:0], i_error_flag_in};
    next_core_error = settle_level(err_sync, core_error);
  end

  always_ff @(posedge i_readout_clk) begin
    if (!i_readout_resetn) begin
      err_sync <= SYNC_RESET;
      core_error <= 1'b0;
    end else begin
      err_sync <= next_err_sync;
      core_error <= next_core_error;
    end
  end

  assign o_core_error = core_error;

  sequence s_load_src0;
    !i_ctrl.shift_not_load && !i_ctrl.load_source_select;
  endsequence

  a_load_pre: assert property (@(posedge i_readout_clk) // see R5
    disable iff (!i_readout_resetn)
    s_load_src0 |=> shift_reg == $past(snap.precomputed))
    else $error("precomputed value not loaded");

  a_load_calc: assert property (@(posedge i_readout_clk) // see R6
    disable iff (!i_readout_resetn)
    !i_ctrl.shift_not_load && i_ctrl.load_source_select
    |=> shift_reg == $past(snap.calculated))
    else $error("calculated value not loaded");

  a_shift_step: assert property (@(posedge i_readout_clk) // see R3
    disable iff (!i_readout_resetn)
    i_ctrl.shift_not_load |=> o_serial_signature_out == $past(shift_reg[1]))
    else $error("shift did not advance one bit");

  a_bit_zero: assert property (@(posedge i_readout_clk) // see R15
    disable iff (!i_readout_resetn)
    !i_ctrl.shift_not_load
    |=> o_serial_signature_out == $past(next_shift_reg[0]))
    else $error("bit 0 not presented after load");

  a_oe_high: assert property (@(posedge i_clk) // see R10
    disable iff (!i_resetn)
    o_error_flag_oe && (o_error_flag_out == err_raw))
    else $error("error pin enable not held high");

  // hold must not move while the readout side may be sampling it
  a_hold_frozen: assert property (@(posedge i_clk) // see R1
    disable iff (!i_resetn)
    busy |=> $stable(hold))
    else $error("crossing word changed while in flight");

  a_req_steady: assert property (@(posedge i_clk) // see R1
    disable iff (!i_resetn)
    busy |=> req == $past(req))
    else $error("request toggled before acknowledge");

  a_snap_take: assert property (@(posedge i_readout_clk) // see R1
    disable iff (!i_readout_resetn)
    (req_seen != ack) |=> snap == $past(hold))
    else $error("readout copy not taken from held word");

  sequence s_pin_high;
    i_error_flag_in [*4];
  endsequence

  a_core_flag: assert property (@(posedge i_readout_clk) // see R9
    disable iff (!i_readout_resetn)
    s_pin_high |=> o_core_error)
    else $error("pin flag did not reach core");

  a_shift_fill: assert property (@(posedge i_readout_clk) // see R3
    disable iff (!i_readout_resetn)
    i_ctrl.shift_not_load |=> !shift_reg[SIG_WIDTH-1])
    else $error("shift did not clear top bit");
endmodule : crc_signature_readout

// [sim/readout_user_model.sv]
// user-logic model: loads the shift register, then clocks out 32 bits
// assumes the bench makes the readout clock and drives start and source
`timescale 1ns/1ps
module readout_user_model (
  // readout side
  input wire logic i_readout_clk,
  input wire logic i_serial,
  output crc_readout_pkg::readout_ctrl_t o_ctrl,
  // bench handshake
  input wire logic i_start,
  input wire logic i_src,
  output logic [31:0] o_word,
  output logic o_done
);
  import crc_readout_pkg::*;
  always begin
    o_ctrl = 2'h2;
    o_done = 1'h0;
    @(posedge i_readout_clk iff i_start);
    #2 o_ctrl = {1'h0, i_src};
    repeat (2) @(posedge i_readout_clk);
    // flipped source while shifting must change nothing
    #2 o_ctrl = {1'h1, ~i_src};
    for (int k = 0; k < 32; k++) begin
      if (k > 0) @(posedge i_readout_clk);
      @(negedge i_readout_clk);
      o_word[k] = i_serial;
    end
    o_done = 1'h1;
    wait (!i_start);
  end
endmodule : readout_user_model

// [sim/testbench.sv]
// bench for the signature readout: two unrelated clocks and a user model
// assumes both resets are synchronous and held for several edges
`timescale 1ns/1ps
module testbench;
  import crc_readout_pkg::*;
  logic i_clk = 1'h0, rclk = 1'h0, i_resetn = 1'h0, rresetn = 1'h0;
  logic check_valid = 1'h0, start = 1'h0, src = 1'h0;
  crc_values_t values = '0;
  readout_ctrl_t ctrl;
  logic serial, flag_out, flag_oe, core_error, done;
  logic [31:0] word;
  wire logic flag_pin;
  int err_count = 0, cmp_count = 0, cycles = 0;
  always #5 i_clk = ~i_clk;
  always #62.5 rclk = ~rclk;
  // no pull on the pin: an undriven pin shows the inverse
  assign flag_pin = flag_oe ? flag_out : ~flag_out;
  crc_signature_readout crc_signature_readout_inst (.i_clk(i_clk),
    .i_resetn(i_resetn), .i_check_valid(check_valid), .i_values(values),
    .i_readout_clk(rclk), .i_readout_resetn(rresetn), .i_ctrl(ctrl),
    .o_serial_signature_out(serial), .o_error_flag_out(flag_out),
    .o_error_flag_oe(flag_oe), .i_error_flag_in(flag_pin),
    .o_core_error(core_error));
  readout_user_model readout_user_model_inst (.i_readout_clk(rclk),
    .i_serial(serial), .o_ctrl(ctrl), .i_start(start), .i_src(src),
    .o_word(word), .o_done(done));
  task check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %0t: got %h want %h", $time, seen, exp);
    end
  endtask : check
  task stop_test;
    $display("compares %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : stop_test
  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 10000) begin
      err_count++;
      stop_test();
    end
  end
  task read_sig(input logic s);
    @(posedge rclk);
    #2 src = s;
    start = 1'h1;
    wait (done);
    @(posedge rclk);
    #2 start = 1'h0;
  endtask : read_sig
  // wait for the flag to cross into the readout domain
  task settle;
    repeat (16) @(posedge rclk);
    #2;
  endtask : settle
  task t_clean;
    values = {32'hA5C3_0F11, 32'hA5C3_0F11};
    check_valid = 1'h1;
    settle();
    read_sig(1'h0);
    check(word, 32'hA5C3_0F11);
    read_sig(1'h1);
    check(word, 32'hA5C3_0F11);
    check(flag_out, 32'h0);
    $display("t_clean done");
  endtask : t_clean
  task t_upset;
    values.calculated = 32'h5A3C_F0EE;
    settle();
    check(flag_out, 32'h1);
    check(flag_oe, 32'h1);
    check(core_error, 32'h1);
    read_sig(1'h0);
    check(word, 32'hA5C3_0F11);
    read_sig(1'h1);
    check(word, 32'h5A3C_F0EE);
    $display("t_upset done");
  endtask : t_upset
  task t_restore;
    values.calculated = 32'hA5C3_0F11;
    @(posedge i_clk);
    #2 i_resetn = 1'h0;
    repeat (3) @(posedge i_clk);
    #2 i_resetn = 1'h1;
    settle();
    check(flag_out, 32'h0);
    check(core_error, 32'h0);
    read_sig(1'h1);
    check(word, 32'hA5C3_0F11);
    $display("t_restore done");
  endtask : t_restore
  initial begin
    repeat (5) @(posedge rclk);
    #2 i_resetn = 1'h1;
    rresetn = 1'h1;
    t_clean();
    t_upset();
    t_restore();
    stop_test();
  end
endmodule : testbench
